// file: rtl/dprc_ctrl.v
// Debug power/reset control and self address offset registers.
// Assumes a single-cycle coprocessor access port on sys_clk; the
// offset and validity straps are static configuration inputs.
//
// Behaviour
// - Power-up request bit drives a power-up request to the controller.
// - Hold-reset bit keeps non-debug logic in reset after resets.
// - Writing one to warm-reset bit issues a warm reset request.
// - Keep-powered bit drives the no-power-down output high.
// - Power-up and hold-reset bits undefined over extended interface.
// - Offset register reads as one 64-bit two-register transfer.
// - Single-register read returns the 32-bit lower half view.
// - Offset register reachable only through the coprocessor port; code also returns it on reads with cp_ext set.
// - Bits 39:12 hold signed offset; bits 63:40 sign-extend it.
// - 32-bit view shows offset bits 31:12; bits 11:2 zero, 1:0 validity.
// - Validity field reads 00 when invalid and 11 when valid.
// - Offset contents unknown when validity reads zero.
`timescale 1ns/100ps
`include "dprc_defs.vh"

module dprc_ctrl #(
  parameter OFS_W = 28
) (
  sys_clk,
  rst_n,
  cp_req,
  cp_write,
  cp_ext,
  cp_wide,
  cp_sel,
  cp_wdata,
  cfg_offset,
  cfg_valid,
  cp_ack,
  cp_rdata,
  pwr_up_req,
  hold_core_rst,
  warm_rst_req,
  no_power_down_out,
  core_rst_done
);
  input  wire              sys_clk;
  input  wire              rst_n;
  input  wire              cp_req;
  input  wire              cp_write;
  input  wire              cp_ext;
  input  wire              cp_wide;
  input  wire [1:0]        cp_sel;
  input  wire [31:0]       cp_wdata;
  input  wire [OFS_W-1:0]  cfg_offset;
  input  wire              cfg_valid;
  input  wire              core_rst_done;
  output reg               cp_ack;
  output reg  [63:0]       cp_rdata;
  output reg               pwr_up_req;
  output reg               hold_core_rst;
  output reg               warm_rst_req;
  output reg               no_power_down_out;

  // ========================================================
  // Input synchroniser for the reset-done level from core domain
  reg  rst_done_s1_ff;
  reg  rst_done_s2_ff;
  reg  rst_done_d_ff;
  wire rst_done_rise;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_done_s1_ff <= 1'b0;
      rst_done_s2_ff <= 1'b0;
      rst_done_d_ff  <= 1'b0;
    end else begin
      rst_done_s1_ff <= core_rst_done;
      rst_done_s2_ff <= rst_done_s1_ff;
      rst_done_d_ff  <= rst_done_s2_ff;
    end
  end

  assign rst_done_rise = rst_done_s2_ff & ~rst_done_d_ff;

  // ========================================================
  // Control register
  reg  [3:0] ctrl_ff;
  reg  [3:0] nxt_ctrl;
  reg        nxt_warm;
  reg        nxt_hold;
  wire       wr_ctrl;

  assign wr_ctrl = cp_req & cp_write & (cp_sel == `DPRC_SEL_CTRL);

  always @* begin
    nxt_ctrl = ctrl_ff;
    nxt_warm = 1'b0;
    if (wr_ctrl) begin
      nxt_ctrl[`DPRC_BIT_KEEP_PWR] = cp_wdata[`DPRC_BIT_KEEP_PWR];
      // Extended writes leave the two undefined bits untouched
      if (!cp_ext) begin
        nxt_ctrl[`DPRC_BIT_PWR_UP]   = cp_wdata[`DPRC_BIT_PWR_UP];
        nxt_ctrl[`DPRC_BIT_HOLD_RST] = cp_wdata[`DPRC_BIT_HOLD_RST];
      end
      // Request bit is never stored, so reads cannot retrigger it
      nxt_warm = cp_wdata[`DPRC_BIT_WARM_RST];
    end
    nxt_ctrl[`DPRC_BIT_WARM_RST] = 1'b0;
  end

  // Core held in reset from a warm request made with the hold bit set until
  // released by a clear of the hold bit; a completed core reset re-arms the hold.
  always @* begin
    nxt_hold = hold_core_rst;
    if (!nxt_ctrl[`DPRC_BIT_HOLD_RST])
      nxt_hold = 1'b0;
    else if (nxt_warm | rst_done_rise)
      nxt_hold = 1'b1;
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff           <= `DPRC_CTRL_RESET;
      warm_rst_req      <= 1'b0;
      hold_core_rst     <= 1'b0;
      pwr_up_req        <= 1'b0;
      no_power_down_out <= 1'b0;
    end else begin
      ctrl_ff           <= nxt_ctrl;
      warm_rst_req      <= nxt_warm;
      hold_core_rst     <= nxt_hold;
      pwr_up_req        <= nxt_ctrl[`DPRC_BIT_PWR_UP];
      no_power_down_out <= nxt_ctrl[`DPRC_BIT_KEEP_PWR];
    end
  end

  // ========================================================
  // Self address offset view
  function [63:0] dprc_offset_word;
    input [OFS_W-1:0] ofs;
    input             vld;
    begin
      // Sign bit replicated into 63:40, low bits zero but validity
      dprc_offset_word = {{(64-OFS_W-12){ofs[OFS_W-1]}}, ofs,
                          10'h000,
                          vld ? `DPRC_VALID_YES : `DPRC_VALID_NO};
    end
  endfunction

  wire [63:0] ofs_word;
  assign ofs_word = dprc_offset_word(cfg_offset, cfg_valid);

  // ========================================================
  // Read path, answered one cycle after the request
  reg  [63:0] nxt_rdata;

  always @* begin
    nxt_rdata = 64'h0;
    if (cp_req & ~cp_write) begin
      case (cp_sel)
        `DPRC_SEL_CTRL: begin
          nxt_rdata[3:0] = ctrl_ff;
          if (cp_ext)
            nxt_rdata[3:2] = 2'h0;
        end
        `DPRC_SEL_OFFSET: begin
          if (cp_wide)
            nxt_rdata = ofs_word;
          else
            nxt_rdata[31:0] = ofs_word[31:0];
        end
        default: begin
          nxt_rdata = 64'h0;
        end
      endcase
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_ack   <= 1'b0;
      cp_rdata <= 64'h0;
    end else begin
      cp_ack   <= cp_req;
      cp_rdata <= nxt_rdata;
    end
  end

endmodule // dprc_ctrl

// file: rtl/dprc_defs.vh
// Constants for the debug power and reset control block.
// Assumes inclusion by bare name from the design file only.
`ifndef DPRC_DEFS_VH
`define DPRC_DEFS_VH
// ==========================================================
// Register selects on the coprocessor port
`define DPRC_SEL_CTRL        2'h0
`define DPRC_SEL_OFFSET      2'h1
// ==========================================================
// Control register fields
`define DPRC_BIT_KEEP_PWR    0
`define DPRC_BIT_WARM_RST    1
`define DPRC_BIT_HOLD_RST    2
`define DPRC_BIT_PWR_UP      3
`define DPRC_CTRL_RESET      4'h0
// ==========================================================
// Offset register fields
`define DPRC_OFS_MSB         39
`define DPRC_OFS_LSB         12
`define DPRC_VALID_YES       2'h3
`define DPRC_VALID_NO        2'h0
`endif

// file: sim/dprc_ctrl_sva.sv
// Port checker for dprc_ctrl.
// Bound into each dprc_ctrl; sees only its ports.
`timescale 1ns/100ps
module dprc_ctrl_sva #(parameter OFS_W = 28) (
  input logic sys_clk, rst_n, cp_req, cp_write, cp_ext, cp_wide,
  input logic [1:0] cp_sel,
  input logic [31:0] cp_wdata,
  input logic [OFS_W-1:0] cfg_offset,
  input logic cfg_valid, cp_ack, pwr_up_req, hold_core_rst,
  input logic warm_rst_req, no_power_down_out,
  input logic [63:0] cp_rdata
);
  // ==========
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire wr = cp_req & cp_write & (cp_sel == 2'h0);
  wire ww = wr & cp_wdata[1];
  wire rd = cp_req & !cp_write & (cp_sel == 2'h1);
  wire [63:0] ofs = {{(52-OFS_W){cfg_offset[OFS_W-1]}}, cfg_offset,
                     10'h000, {2{cfg_valid}}};
  sequence one_pulse; warm_rst_req ##1 !warm_rst_req; endsequence
  a_ack_next: assert property (cp_req |=> cp_ack) else $error("no ack");
  a_keep_pwr: assert property (
    wr |=> no_power_down_out == $past(cp_wdata[0])) else $error("npd");
  a_pwr_up: assert property (
    wr && !cp_ext |=> pwr_up_req == $past(cp_wdata[3])) else $error("pwr");
  a_ext_keep: assert property (
    wr && cp_ext |=> $stable(pwr_up_req)) else $error("ext pwr");
  a_warm_once: assert property (ww |=> one_pulse) else $error("warm");
  a_warm_cause: assert property (
    warm_rst_req |-> $past(ww)) else $error("warm cause");
  a_hold_clr: assert property (
    wr && !cp_ext && !cp_wdata[2] |=> !hold_core_rst) else $error("hold");
  a_ofs_wide: assert property (
    rd && cp_wide |=> cp_rdata == ofs) else $error("wide");
  a_ofs_narrow: assert property (
    rd && !cp_wide |=> cp_rdata == {32'h0, ofs[31:0]}) else $error("narrow");
endmodule // dprc_ctrl_sva
bind dprc_ctrl dprc_ctrl_sva #(.OFS_W(OFS_W)) u_sva (.*);

// file: sim/dprc_pwr_model.sv
// Power controller model facing dprc_ctrl.
// Warm reset ends DLY cycles after the request pulse.
`timescale 1ns/100ps
module dprc_pwr_model #(parameter logic [7:0] DLY = 8'h04) (
  input wire logic sys_clk, rst_n, warm_rst_req, no_power_down_out, pd_req,
  output logic core_rst_done,
  output wire logic powered
);
  // ==========
  // Behaviour
  logic [7:0] cnt_ff;
  // Emulate mode: power-down requests are ignored while no_power_down_out is high
  assign powered = no_power_down_out | !pd_req;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      core_rst_done <= 1'b0;
    end else if (warm_rst_req) begin
      cnt_ff <= DLY;
      core_rst_done <= 1'b0;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
      core_rst_done <= (cnt_ff == 8'h01);
    end
  end
endmodule // dprc_pwr_model

// file: sim/tb_dprc_ctrl.sv
// Self-checking bench for dprc_ctrl with a power controller model.
// Read words are queued by the driver and checked on cp_ack.
`timescale 1ns/100ps
module tb_dprc_ctrl;
  logic sys_clk, rst_n, cp_req, cp_write, cp_ext, cp_wide, cfg_valid;
  logic [1:0] cp_sel;
  logic [31:0] cp_wdata;
  logic [27:0] cfg_offset, o;
  logic [63:0] cp_rdata, w, q[$];
  logic cp_ack, pwr_up_req, hold_core_rst, warm_rst_req, pd_req, powered;
  logic no_power_down_out, core_rst_done;
  int errors, check_count, seed = 40086;
  dprc_ctrl dut (.*);
  dprc_pwr_model #(.DLY(8'h06)) u_pwr (.*);
  // ==========
  // Tasks
  initial begin sys_clk = 1'b0; forever #5 sys_clk = ~sys_clk; end
  task chk(string n, logic [63:0] e, logic [63:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task acc(logic a, x, d, logic [1:0] s, logic [31:0] v, logic [63:0] e);
    @(posedge sys_clk);
    {cp_req, cp_write, cp_ext, cp_wide, cp_sel, cp_wdata} <= {1'b1,a,x,d,s,v};
    q.push_back(e);
  endtask
  task idle;
    @(posedge sys_clk);
    cp_req <= 1'b0;
    #1;
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk)
    if (cp_ack === 1'b1) chk("rdata", q.pop_front(), cp_rdata);
  initial begin #5000; errors++; results; end
  // ==========
  // Scenarios
  initial begin
    {rst_n, cp_req, cp_write, cp_ext, cp_wide, cp_sel, cp_wdata} = '0;
    {cfg_offset, cfg_valid, pd_req} = 30'h1;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    acc(1, 0, 0, 2'h0, 32'h9, 0);
    acc(1, 1, 0, 2'h0, 32'h1, 0);
    acc(0, 1, 0, 2'h0, 32'h0, 64'h1);
    acc(0, 0, 0, 2'h0, 32'h0, 64'h9);
    idle;
    chk("pwr", 1, pwr_up_req);
    chk("npd", 1, powered & no_power_down_out);
    acc(1, 0, 0, 2'h0, 32'h6, 0);
    idle;
    chk("warm", 1, warm_rst_req);
    chk("npd", 0, no_power_down_out);
    repeat (10) @(posedge sys_clk);
    #1 chk("hold", 1, hold_core_rst);
    acc(1, 0, 0, 2'h0, 32'h0, 0);
    acc(0, 0, 1, 2'h3, 32'h0, 0);
    idle;
    chk("hold", 0, hold_core_rst);
    for (int i = 0; i < 6; i++) begin
      o = 28'($random(seed));
      w = {{24{o[27]}}, o, 10'h000, {2{i[0]}}};
      acc(0, 0, 1, 2'h1, 32'h0, w);
      cfg_offset <= o;
      cfg_valid <= i[0];
      acc(0, 0, 0, 2'h1, 32'h0, {32'h0, w[31:0]});
      idle;
    end
    repeat (2) @(posedge sys_clk);
    results;
  end
endmodule // tb_dprc_ctrl
